/* core/fcg_pkg.sv */
// constants for the fan controller global configuration block
package fcg_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] GCFG_ADDR = 8'h00;
  localparam logic [7:0] GCFG_RST = 8'h00;
  // ==========================================================
  // field positions of the global configuration register
  localparam int BIT_STANDBY = 7;
  localparam int BIT_SOFT_RST = 6;
  localparam int BIT_BUS_TO_DIS = 5;
  localparam int BIT_FAIL_FULL_DIS = 4;
  localparam int BIT_OSC_XTAL = 3;
  localparam int BIT_WD_HI = 2;
  localparam int BIT_WD_LO = 1;
  localparam int BIT_WD_STAT = 0;
  // ==========================================================
  // watchdog period codes
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_SEL1 = 2'h1;
  localparam logic [1:0] WD_SEL2 = 2'h2;
  localparam logic [1:0] WD_SEL3 = 2'h3;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned WD_P1_S = 2;
  localparam int unsigned WD_P2_S = 6;
  localparam int unsigned WD_P3_S = 10;
  localparam int unsigned BUS_TO_MS = 35;
  localparam int unsigned WD1_CYC = WD_P1_S * CLK_HZ;
  localparam int unsigned WD2_CYC = WD_P2_S * CLK_HZ;
  localparam int unsigned WD3_CYC = WD_P3_S * CLK_HZ;
  localparam int unsigned BUS_TO_CYC = BUS_TO_MS * (CLK_HZ / 1000);
  localparam int NUM_FANS = 4;
endpackage

/* core/fcg_wd_if.sv */
// link between the configuration register and the watchdog timer
`timescale 1ns/1ns
interface fcg_wd_if;
  logic [1:0] period_sel;
  logic kick;
  logic clear;
  logic expired;
  modport ctrl (output period_sel, output kick, output clear, input expired);
  modport timer (input period_sel, input kick, input clear, output expired);
endinterface

/* core/fcg_wd_timer.sv */
// bus watchdog timer with selectable period
`timescale 1ns/1ns
module fcg_wd_timer #(
  parameter int unsigned WD1_CYC = fcg_pkg::WD1_CYC,
  parameter int unsigned WD2_CYC = fcg_pkg::WD2_CYC,
  parameter int unsigned WD3_CYC = fcg_pkg::WD3_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  fcg_wd_if.timer wd
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] lim;
  logic active;
  logic hit;
  logic expired_r;
  logic expired_nxt;

  // ==========================================================
  // period decode
  assign lim = (wd.period_sel == fcg_pkg::WD_SEL1) ? 32'(WD1_CYC) :
               (wd.period_sel == fcg_pkg::WD_SEL2) ? 32'(WD2_CYC) : 32'(WD3_CYC);
  assign active = (wd.period_sel != fcg_pkg::WD_OFF); // RULE12
  assign hit = active && (cnt_r >= lim - 32'h0000_0001);
  // a valid transaction restarts the count and lifts the timeout
  assign cnt_nxt = (wd.kick || wd.clear || !active || expired_r) ? 32'h0000_0000 :
                   cnt_r + 32'h0000_0001; // RULE9
  assign expired_nxt = (wd.kick || wd.clear || !active) ? 1'b0 :
                       (hit ? 1'b1 : expired_r); // RULE10 RULE11
  assign wd.expired = expired_r;

  // counter and timeout flag
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
      expired_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  property p_kick_clears;
    @(posedge clk_sys_i) disable iff (rst_i) wd.kick |=> !expired_r && cnt_r == 32'h0000_0000;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("kick did not restart watchdog"); // RULE9

  property p_expire;
    @(posedge clk_sys_i) disable iff (rst_i)
      (active && !wd.kick && !wd.clear && cnt_r == lim - 32'h0000_0001) |=> expired_r;
  endproperty
  a_expire: assert property (p_expire) else $error("watchdog missed its period"); // RULE10

  property p_off_never_expires;
    @(posedge clk_sys_i) disable iff (rst_i) (wd.period_sel == fcg_pkg::WD_OFF) |=> !expired_r;
  endproperty
  a_off_never_expires: assert property (p_off_never_expires) else $error("disabled watchdog expired"); // RULE12
endmodule

/* core/fcg_gcfg_top.sv */
// global configuration register, bus timeout, fan fail policy and watchdog
// Notes on behaviour
// (RULE1) bit 7: 0 run, 1 standby
// (RULE2) writing bit 6 restores power-on values
// (RULE3) soft reset bit always reads zero
// (RULE4) bit 5 low: reset bus after 35ms
// (RULE5) bit 4 low: one failure forces others full
// (RULE6) bit 3 picks internal or crystal source
// (RULE7) stay internal until crystal has started
// (RULE8) dead crystal means internal oscillator continues
// (RULE9) valid transactions restart the watchdog count
// (RULE10) watchdog timeout drives all fans full
// (RULE11) resumed traffic restores previous fan drive
// (RULE12) bits 2:1: off, 2s, 6s, 10s
// (RULE13) period field loads from strap at power-up
// (RULE14) master should access device periodically
// (RULE15) read-only watchdog status bit
// (RULE16) status at bit 0, writes ignored
`timescale 1ns/1ns
module fcg_gcfg_top #(
  parameter int unsigned BUS_TO_CYC = fcg_pkg::BUS_TO_CYC,
  parameter int unsigned WD1_CYC = fcg_pkg::WD1_CYC,
  parameter int unsigned WD2_CYC = fcg_pkg::WD2_CYC,
  parameter int unsigned WD3_CYC = fcg_pkg::WD3_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic txn_valid_i,
  input wire logic sda_i,
  input wire logic watchdog_default_strap_pin_i,
  input wire logic xtal_running_i,
  input wire logic [3:0] fan_fail_i,
  output logic standby_o,
  output logic soft_reset_o,
  output logic i2c_reset_o,
  output logic osc_xtal_o,
  output logic [3:0] force_full_o
);
  fcg_wd_if wd ();

  // ==========================================================
  // register state
  logic standby_r;
  logic bus_to_dis_r;
  logic fail_full_dis_r;
  logic osc_sel_r;
  logic [1:0] wd_sel_r;
  logic strap_pend_r;
  logic soft_reset_r;
  logic [7:0] rdata_r;
  logic i2c_reset_r;
  logic osc_xtal_r;
  logic [3:0] force_full_r;
  logic [31:0] sda_lo_cnt_r;
  logic [31:0] sda_lo_cnt_nxt;

  // ==========================================================
  // access decode
  logic cfg_hit;
  logic cfg_wr;
  logic cfg_rd;
  logic do_soft_rst;
  logic [7:0] cfg_view;
  logic [7:0] rdata_nxt;
  logic sda_stuck;

  assign cfg_hit = (reg_addr_i == fcg_pkg::GCFG_ADDR);
  assign cfg_wr = reg_wr_i && cfg_hit;
  assign cfg_rd = reg_rd_i && cfg_hit;
  assign do_soft_rst = cfg_wr && reg_wdata_i[fcg_pkg::BIT_SOFT_RST]; // RULE2

  // readback: soft reset bit is never stored, status is live
  assign cfg_view = {standby_r, 1'b0, bus_to_dis_r, fail_full_dis_r, osc_sel_r,
                     wd_sel_r, wd.expired}; // RULE3 RULE15 RULE16
  // unmapped addresses read as zero
  assign rdata_nxt = cfg_rd ? cfg_view : (reg_rd_i ? 8'h00 : rdata_r);

  // control bits; a soft reset wins over the rest of the same write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      standby_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_STANDBY];
      bus_to_dis_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_BUS_TO_DIS];
      fail_full_dis_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_FAIL_FULL_DIS];
      osc_sel_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_OSC_XTAL];
    end else if (do_soft_rst) begin
      standby_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_STANDBY]; // RULE2
      bus_to_dis_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_BUS_TO_DIS];
      fail_full_dis_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_FAIL_FULL_DIS];
      osc_sel_r <= fcg_pkg::GCFG_RST[fcg_pkg::BIT_OSC_XTAL];
    end else if (cfg_wr) begin
      standby_r <= reg_wdata_i[fcg_pkg::BIT_STANDBY]; // RULE1
      bus_to_dis_r <= reg_wdata_i[fcg_pkg::BIT_BUS_TO_DIS]; // RULE4
      fail_full_dis_r <= reg_wdata_i[fcg_pkg::BIT_FAIL_FULL_DIS]; // RULE5
      osc_sel_r <= reg_wdata_i[fcg_pkg::BIT_OSC_XTAL]; // RULE6
    end
  end

  // period field: strap is caught one cycle after reset or soft reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wd_sel_r <= fcg_pkg::WD_OFF;
      strap_pend_r <= 1'b1;
    end else if (do_soft_rst) begin
      strap_pend_r <= 1'b1;
    end else if (strap_pend_r) begin
      wd_sel_r <= watchdog_default_strap_pin_i ? fcg_pkg::WD_SEL3 : fcg_pkg::WD_OFF; // RULE13
      strap_pend_r <= 1'b0;
    end else if (cfg_wr) begin
      wd_sel_r <= reg_wdata_i[fcg_pkg::BIT_WD_HI:fcg_pkg::BIT_WD_LO]; // RULE12
    end
  end

  // ==========================================================
  // watchdog hookup; any valid transaction counts as a kick
  assign wd.period_sel = wd_sel_r;
  assign wd.kick = txn_valid_i; // RULE9 RULE11
  assign wd.clear = do_soft_rst || strap_pend_r;

  fcg_wd_timer #(
    .WD1_CYC(WD1_CYC),
    .WD2_CYC(WD2_CYC),
    .WD3_CYC(WD3_CYC)
  ) u_wd (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wd(wd)
  );

  // ==========================================================
  // bus stuck timeout: counts while data line is held low
  // stuck while the line is still low and the count equals the limit
  assign sda_stuck = !bus_to_dis_r && !sda_i && (sda_lo_cnt_r == BUS_TO_CYC); // RULE4
  // counter parks one past the limit so the reset pulse fires once per stuck episode
  assign sda_lo_cnt_nxt = (sda_i || bus_to_dis_r) ? 32'h0000_0000 :
                          ((sda_lo_cnt_r > BUS_TO_CYC) ? sda_lo_cnt_r : sda_lo_cnt_r + 32'h0000_0001);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_lo_cnt_r <= 32'h0000_0000;
      i2c_reset_r <= 1'b0;
    end else begin
      sda_lo_cnt_r <= sda_lo_cnt_nxt;
      i2c_reset_r <= sda_stuck; // RULE4
    end
  end

  // ==========================================================
  // fan full-drive policy, one term per channel
  genvar g;
  generate
    for (g = 0; g < fcg_pkg::NUM_FANS; g++) begin : g_fan
      logic other_fail;
      assign other_fail = |(fan_fail_i & ~(4'h1 << g));
      // forcing is released one cycle after the watchdog flag drops, so the
      // drive registers elsewhere keep their previous value
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          force_full_r[g] <= 1'b0;
        end else begin
          force_full_r[g] <= (!fail_full_dis_r && other_fail) || wd.expired; // RULE5 RULE10 RULE11
        end
      end
    end
  endgenerate

  // ==========================================================
  // clock source: crystal used only while it reports running
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_xtal_r <= 1'b0;
    end else begin
      osc_xtal_r <= osc_sel_r && xtal_running_i; // RULE7 RULE8
    end
  end

  // read data and soft reset pulse
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      soft_reset_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      soft_reset_r <= do_soft_rst; // RULE2
    end
  end

  assign reg_rdata_o = rdata_r;
  assign standby_o = standby_r;
  assign soft_reset_o = soft_reset_r;
  assign i2c_reset_o = i2c_reset_r;
  assign osc_xtal_o = osc_xtal_r;
  assign force_full_o = force_full_r;

  // ==========================================================
  // checks
  property p_standby;
    @(posedge clk_sys_i) disable iff (rst_i)
      (cfg_wr && !do_soft_rst) |=> standby_o == $past(reg_wdata_i[fcg_pkg::BIT_STANDBY]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby bit not applied"); // RULE1

  property p_soft_rst;
    @(posedge clk_sys_i) disable iff (rst_i)
      do_soft_rst |=> soft_reset_o && !standby_o && !osc_sel_r && strap_pend_r;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset did not restore values"); // RULE2

  property p_rst_bit_zero;
    @(posedge clk_sys_i) disable iff (rst_i) $past(cfg_rd) |-> !reg_rdata_o[fcg_pkg::BIT_SOFT_RST];
  endproperty
  a_rst_bit_zero: assert property (p_rst_bit_zero) else $error("soft reset bit read back as one"); // RULE3

  property p_bus_to;
    @(posedge clk_sys_i) disable iff (rst_i)
      i2c_reset_o |-> !$past(sda_i) && !$past(bus_to_dis_r) && $past(sda_lo_cnt_r) == BUS_TO_CYC;
  endproperty
  a_bus_to: assert property (p_bus_to) else $error("bus reset without stuck data line"); // RULE4

  property p_bus_to_once;
    @(posedge clk_sys_i) disable iff (rst_i) i2c_reset_o |=> !i2c_reset_o;
  endproperty
  a_bus_to_once: assert property (p_bus_to_once) else $error("bus reset pulse repeated"); // RULE4

  property p_fail_full;
    @(posedge clk_sys_i) disable iff (rst_i) (!fail_full_dis_r && fan_fail_i[0]) |=> force_full_o[1];
  endproperty
  a_fail_full: assert property (p_fail_full) else $error("fan failure did not force others full"); // RULE5

  property p_xtal;
    @(posedge clk_sys_i) disable iff (rst_i) osc_xtal_o |-> $past(osc_sel_r && xtal_running_i);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal used before it started"); // RULE7

  property p_xtal_fail;
    @(posedge clk_sys_i) disable iff (rst_i) !xtal_running_i |=> !osc_xtal_o;
  endproperty
  a_xtal_fail: assert property (p_xtal_fail) else $error("no fallback to internal oscillator"); // RULE8

  property p_wd_full;
    @(posedge clk_sys_i) disable iff (rst_i) wd.expired |=> force_full_o == 4'hF;
  endproperty
  a_wd_full: assert property (p_wd_full) else $error("watchdog timeout did not force fans"); // RULE10

  property p_strap;
    @(posedge clk_sys_i) disable iff (rst_i)
      (strap_pend_r && !do_soft_rst) |=> wd_sel_r == {2{$past(watchdog_default_strap_pin_i)}};
  endproperty
  a_strap: assert property (p_strap) else $error("period field not loaded from strap"); // RULE13

  property p_status;
    @(posedge clk_sys_i) disable iff (rst_i) cfg_rd |=> reg_rdata_o[0] == $past(wd.expired);
  endproperty
  a_status: assert property (p_status) else $error("watchdog status misreported"); // RULE15
endmodule

/* tb/fcg_host_model.sv */
// bus master model issuing register cycles and watchdog kicks
`timescale 1ns/1ns
module fcg_host_model (
  input wire logic clk_sys_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic txn_valid_o
);
  // idle bus at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
    txn_valid_o = 1'b0;
  end
  // one byte write, strobe held for exactly one taking edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~data; // stale data is never left looking valid
  endtask
  // one byte read, data taken just after the edge that samples the read strobe
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1;
    data = reg_rdata_i;
  endtask
  // one completed transaction, keeps the watchdog fed
  task automatic kick();
    @(posedge clk_sys_i);
    txn_valid_o <= 1'b1;
    @(posedge clk_sys_i);
    txn_valid_o <= 1'b0;
  endtask
endmodule

/* tb/tb_fan_ctrl_global_config_watchdog.sv */
// self-checking bench for the global configuration block
`timescale 1ns/1ns
module tb_fan_ctrl_global_config_watchdog;
  // ==========================================================
  // shortened counts so the run stays small
  localparam int unsigned TO_CYC = 20;
  localparam int PER[3] = '{40, 60, 100};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
  logic reg_wr, reg_rd, txn_valid;
  logic sda_i = 1'b1;
  logic strap = 1'b1;
  logic xtal = 1'b0;
  logic [3:0] fan_fail = 4'h0;
  logic standby, soft_rst, i2c_rst, osc_xtal;
  logic [3:0] force_full;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_srst = 0;
  int n_i2c = 0;
  int n0;
  always #4 clk_sys_i = ~clk_sys_i;
  fcg_host_model i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .txn_valid_o(txn_valid));
  fcg_gcfg_top #(.BUS_TO_CYC(TO_CYC), .WD1_CYC(PER[0]), .WD2_CYC(PER[1]), .WD3_CYC(PER[2])) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .txn_valid_i(txn_valid),
    .sda_i(sda_i), .watchdog_default_strap_pin_i(strap), .xtal_running_i(xtal),
    .fan_fail_i(fan_fail), .standby_o(standby), .soft_reset_o(soft_rst), .i2c_reset_o(i2c_rst),
    .osc_xtal_o(osc_xtal), .force_full_o(force_full));
  // ==========================================================
  // pulse counters and the hang limit
  always @(posedge clk_sys_i) begin
    cycles++;
    if (soft_rst === 1'b1) n_srst++;
    if (i2c_rst === 1'b1) n_i2c++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read and compare in one call
  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp, input string what);
    i_host.rd(addr, rdv);
    chk(what, exp, rdv);
  endtask
  // let updates of the last edge land before looking
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    step(2);
    rdc(8'h00, 8'h06, "cfg after power-up");
    chk("osc", 8'h00, {7'h0, osc_xtal});
    i_host.wr(8'h00, 8'h00);
    i_host.wr(8'h00, 8'hBF);
    rdc(8'h00, 8'hBE, "cfg written");
    chk("standby", 8'h01, {7'h0, standby});
    chk("osc no crystal", 8'h00, {7'h0, osc_xtal});
    @(posedge clk_sys_i);
    xtal <= 1'b1;
    step(3);
    chk("osc crystal up", 8'h01, {7'h0, osc_xtal});
    @(posedge clk_sys_i);
    xtal <= 1'b0;
    step(3);
    chk("osc crystal lost", 8'h00, {7'h0, osc_xtal});
    i_host.wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00, "unmapped read");
    i_host.wr(8'h00, 8'h88);
    n0 = n_srst;
    i_host.wr(8'h00, 8'h40);
    rdc(8'h00, 8'h06, "cfg after soft reset");
    chk("soft reset pulses", 8'h01, 8'(n_srst - n0));
    chk("standby after soft reset", 8'h00, {7'h0, standby});
    @(posedge clk_sys_i);
    strap <= 1'b0;
    i_host.wr(8'h00, 8'h40);
    rdc(8'h00, 8'h00, "cfg strap low");
    // stuck data line, timeout enabled then disabled
    for (int d = 0; d < 2; d++) begin
      i_host.wr(8'h00, d ? 8'h20 : 8'h00);
      n0 = n_i2c;
      @(posedge clk_sys_i);
      sda_i <= 1'b0;
      step(TO_CYC + 10);
      @(posedge clk_sys_i);
      sda_i <= 1'b1;
      step(2);
      chk("bus timeout pulses", d ? 8'h00 : 8'h01, 8'(n_i2c - n0));
    end
    // single fan failure, policy enabled then disabled
    i_host.wr(8'h00, 8'h00);
    @(posedge clk_sys_i);
    fan_fail <= 4'h1;
    step(2);
    chk("force on fail", 8'h0E, {4'h0, force_full});
    i_host.wr(8'h00, 8'h10);
    step(2);
    chk("force policy off", 8'h00, {4'h0, force_full});
    @(posedge clk_sys_i);
    fan_fail <= 4'h0;
    // every watchdog period code
    for (int i = 1; i < 4; i++) begin
      i_host.wr(8'h00, {5'h0, 2'(i), 1'b0});
      i_host.kick();
      step(PER[i-1] - 5);
      chk("force before period", 8'h00, {4'h0, force_full});
      i_host.kick();
      step(PER[i-1] - 5);
      chk("force after restart", 8'h00, {4'h0, force_full});
      step(10);
      chk("force on timeout", 8'h0F, {4'h0, force_full});
      rdc(8'h00, {5'h0, 2'(i), 1'b1}, "status on timeout");
      i_host.kick();
      step(3);
      chk("force after resume", 8'h00, {4'h0, force_full});
    end
    i_host.wr(8'h00, 8'h00);
    step(150);
    chk("watchdog off", 8'h00, {4'h0, force_full});
    report_and_stop();
  end
endmodule
